// file: asr_pkg.sv
// shared constants for the audio serial status register block
package asr_pkg;
  // register byte offsets
  localparam logic [11:0] ASR_STATUS_OFS = 12'h000;
  localparam logic [11:0] ASR_TXCTL_OFS = 12'h004;
  localparam logic [11:0] ASR_RXCTL_OFS = 12'h008;
  localparam logic [11:0] ASR_MASK_OFS = 12'h00c;
  // reset values
  localparam logic [31:0] ASR_STATUS_RST = 32'h0000_0808;
  localparam logic [31:0] ASR_TXCTL_RST = 32'h0000_0000;
  localparam logic [31:0] ASR_RXCTL_RST = 32'h0000_0008;
  localparam logic [31:0] ASR_MASK_RST = 32'h0000_0000;
  // status word field positions
  localparam int ASR_RXERR_BIT = 15;
  localparam int ASR_RXL_BIT = 14;
  localparam int ASR_RXR_BIT = 13;
  localparam int ASR_TXL_FLD_LSB = 8;
  localparam int ASR_TXERR_BIT = 7;
  localparam int ASR_TXL_BIT = 6;
  localparam int ASR_TXR_BIT = 5;
  localparam int ASR_TXR_FLD_LSB = 0;
  localparam int ASR_WS_HI_LSB = 29;
  localparam int ASR_RXL_FLD_LSB = 24;
  localparam int ASR_WS_LO_LSB = 21;
  localparam int ASR_RXR_FLD_LSB = 16;
  // control register field positions (same layout for transmit and receive)
  localparam int ASR_CTL_RIGHT_BIT = 0;
  localparam int ASR_CTL_LEFT_BIT = 1;
  localparam int ASR_CTL_ERR_BIT = 2;
  localparam int ASR_CTL_MODE_BIT = 3;
  localparam int ASR_CTL_THR_LSB = 4;
  localparam int ASR_THR_W = 4;
  // fifo status field codes
  localparam logic [4:0] ASR_FLD_OVERRUN = 5'h1f;
  localparam logic [4:0] ASR_FLD_UNDERRUN = 5'h1e;
  localparam logic [3:0] ASR_FIFO_DEPTH = 4'h8;
  localparam logic [4:0] ASR_WS_MAX = 5'h1f;
endpackage

// file: asr_ws_if.sv
// carrier between the status register and the word-select length meter
`timescale 1ns/100ps
interface asr_ws_if (
  input wire logic pclk,
  input wire logic presetn
);
  logic ws_pin;
  logic bclk_pin;
  logic [4:0] length;
  modport meter (input pclk, input presetn, input ws_pin, input bclk_pin, output length);
  modport host (output ws_pin, output bclk_pin, input length);
endinterface

// file: asr_ws_meter.sv
// measures one word-select phase in serial bit-clock periods
`timescale 1ns/100ps
module asr_ws_meter (
  asr_ws_if.meter ws
);
  import asr_pkg::*;

  logic bclk_prev_q;
  logic ws_last_q;
  logic [4:0] cnt_q;
  logic [4:0] len_q;
  wire bclk_rise = ws.bclk_pin & ~bclk_prev_q;
  wire phase_end = bclk_rise & (ws.ws_pin != ws_last_q);
  wire [4:0] cnt_inc = (cnt_q == ASR_WS_MAX) ? cnt_q : cnt_q + 5'h01;

  ////////////////////////////////////////////////////////////////////////////
  // pins are synchronous to pclk, so edges are found by a plain delayed copy
  always_ff @(posedge ws.pclk or negedge ws.presetn) begin
    if (!ws.presetn) begin
      bclk_prev_q <= 1'b0;
      ws_last_q <= 1'b0;
      cnt_q <= 5'h00;
      len_q <= 5'h00;
    end else begin
      bclk_prev_q <= ws.bclk_pin;
      if (bclk_rise) begin
        ws_last_q <= ws.ws_pin;
        cnt_q <= phase_end ? 5'h01 : cnt_inc; // saturates, long phases read 31
      end
      if (phase_end) begin
        len_q <= cnt_q;
      end
    end
  end

  assign ws.length = len_q;

  AST_WS_LATCH: assert property (@(posedge ws.pclk) disable iff (!ws.presetn)
    phase_end |=> ws.length == $past(cnt_q))
    else $error("word-select length not latched at phase end");
endmodule

// file: asr_status.sv
// audio serial status register with pending bits, control bits and apb slave
`timescale 1ns/100ps
module asr_status (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] tx_right_level,
  input wire logic [3:0] tx_left_level,
  input wire logic [3:0] rx_right_level,
  input wire logic [3:0] rx_left_level,
  input wire logic tx_right_wr_full,
  input wire logic tx_right_rd_empty,
  input wire logic tx_left_wr_full,
  input wire logic tx_left_rd_empty,
  input wire logic rx_right_wr_full,
  input wire logic rx_right_rd_empty,
  input wire logic rx_left_wr_full,
  input wire logic rx_left_rd_empty,
  input wire logic word_select_pin,
  input wire logic serial_bit_clock_pin,
  output logic irq
);
  import asr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // field encoding shared by all four fifo fields
  function automatic logic [4:0] fifo_field(
    input logic [3:0] filled,
    input logic wr_full,
    input logic rd_empty,
    input logic count_filled
  );
    logic [3:0] shown;
    shown = count_filled ? filled : ASR_FIFO_DEPTH - filled;
    if (wr_full) begin
      fifo_field = ASR_FLD_OVERRUN;
    end else if (rd_empty) begin
      fifo_field = ASR_FLD_UNDERRUN;
    end else begin
      fifo_field = {1'b0, shown};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] tx_ctl_q;
  logic [31:0] rx_ctl_q;
  logic [5:0] mask_q;
  logic [5:0] pend_q;
  logic [5:0] pend_d;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // word-select length meter
  asr_ws_if ws_bus (
    .pclk(pclk),
    .presetn(presetn)
  );
  assign ws_bus.ws_pin = word_select_pin;
  assign ws_bus.bclk_pin = serial_bit_clock_pin;

  asr_ws_meter u_meter (
    .ws(ws_bus.meter)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control bit decode
  wire tx_right_irq_enable = tx_ctl_q[ASR_CTL_RIGHT_BIT];
  wire tx_left_irq_enable = tx_ctl_q[ASR_CTL_LEFT_BIT];
  wire tx_error_irq_enable = tx_ctl_q[ASR_CTL_ERR_BIT];
  wire tx_count_mode = tx_ctl_q[ASR_CTL_MODE_BIT];
  wire [3:0] tx_level_threshold = tx_ctl_q[ASR_CTL_THR_LSB +: ASR_THR_W];
  wire rx_right_irq_enable = rx_ctl_q[ASR_CTL_RIGHT_BIT];
  wire rx_left_irq_enable = rx_ctl_q[ASR_CTL_LEFT_BIT];
  wire rx_error_irq_enable = rx_ctl_q[ASR_CTL_ERR_BIT];
  wire rx_count_mode = rx_ctl_q[ASR_CTL_MODE_BIT];
  wire [3:0] rx_level_threshold = rx_ctl_q[ASR_CTL_THR_LSB +: ASR_THR_W];

  ////////////////////////////////////////////////////////////////////////////
  // live fifo fields; never latched, so an underrun can vanish before a read
  wire [4:0] tx_right_fill_level = fifo_field(tx_right_level, tx_right_wr_full,
                                              tx_right_rd_empty, tx_count_mode);
  wire [4:0] tx_left_fill_level = fifo_field(tx_left_level, tx_left_wr_full,
                                             tx_left_rd_empty, tx_count_mode);
  wire [4:0] rx_right_fill_level = fifo_field(rx_right_level, rx_right_wr_full,
                                              rx_right_rd_empty, rx_count_mode);
  wire [4:0] rx_left_fill_level = fifo_field(rx_left_level, rx_left_wr_full,
                                             rx_left_rd_empty, rx_count_mode);
  wire [4:0] word_select_phase_length = ws_bus.length;

  ////////////////////////////////////////////////////////////////////////////
  // set conditions compare raw filled counts, so count mode has no say here
  wire set_txr = tx_right_irq_enable & (tx_right_level < tx_level_threshold);
  wire set_txl = tx_left_irq_enable & (tx_left_level < tx_level_threshold);
  wire set_txe = tx_error_irq_enable & (tx_right_rd_empty | tx_left_rd_empty);
  wire set_rxr = rx_right_irq_enable & (rx_right_level > rx_level_threshold);
  wire set_rxl = rx_left_irq_enable & (rx_left_level > rx_level_threshold);
  wire set_rxe = rx_error_irq_enable & (rx_right_wr_full | rx_left_wr_full);
  // pending order: rx err, rx left, rx right, tx err, tx left, tx right
  wire [5:0] pend_set = {set_rxe, set_rxl, set_rxr, set_txe, set_txl, set_txr};

  ////////////////////////////////////////////////////////////////////////////
  // status word assembly
  wire [31:0] status_word = {1'b0, word_select_phase_length[4:3], rx_left_fill_level,
                             word_select_phase_length[2:0], rx_right_fill_level,
                             pend_q[5], pend_q[4], pend_q[3], tx_left_fill_level,
                             pend_q[2], pend_q[1], pend_q[0], tx_right_fill_level};
  wire [31:0] mask_word = {16'h0000, mask_q[5], mask_q[4], mask_q[3], 5'h00,
                           mask_q[2], mask_q[1], mask_q[0], 5'h00};

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; one wait state gives the read data a flop to come from
  wire apb_acc = psel & penable;
  wire apb_first = apb_acc & ~pready_q;
  wire apb_done = apb_acc & pready_q;
  wire [11:0] word_addr = {paddr[11:2], 2'b00};
  wire hit_status = (word_addr == ASR_STATUS_OFS);
  wire hit_txctl = (word_addr == ASR_TXCTL_OFS);
  wire hit_rxctl = (word_addr == ASR_RXCTL_OFS);
  wire hit_mask = (word_addr == ASR_MASK_OFS);
  wire hit_any = hit_status | hit_txctl | hit_rxctl | hit_mask;
  wire wr_done = apb_done & pwrite & hit_any;
  wire [31:0] rd_mux = hit_status ? status_word :
                       hit_txctl ? tx_ctl_q :
                       hit_rxctl ? rx_ctl_q :
                       hit_mask ? mask_word : 32'h0000_0000;
  wire [5:0] wr_pend_bits = {pwdata[ASR_RXERR_BIT], pwdata[ASR_RXL_BIT], pwdata[ASR_RXR_BIT],
                             pwdata[ASR_TXERR_BIT], pwdata[ASR_TXL_BIT], pwdata[ASR_TXR_BIT]};
  wire [5:0] pend_clr = (wr_done & hit_status) ? wr_pend_bits : 6'h00;

  // a set in the clearing cycle wins, so a lasting condition keeps its bit
  assign pend_d = pend_set | (pend_q & ~pend_clr);

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake and read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= apb_first;
      pslverr_q <= apb_first & ~hit_any;
      if (apb_first && !pwrite) begin
        prdata_q <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ctl_q <= ASR_TXCTL_RST;
      rx_ctl_q <= ASR_RXCTL_RST;
      mask_q <= ASR_MASK_RST[5:0];
    end else if (wr_done) begin
      if (hit_txctl) begin
        tx_ctl_q <= {24'h000000, pwdata[7:0]};
      end
      if (hit_rxctl) begin
        rx_ctl_q <= {24'h000000, pwdata[7:0]};
      end
      if (hit_mask) begin
        mask_q <= wr_pend_bits;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending bits and the single interrupt line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 6'h00;
      irq_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      irq_q <= |(pend_q & mask_q);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_RESET_WORD: assert property (@(posedge pclk)
    ($rose(presetn) && tx_right_level == 4'h0 && tx_left_level == 4'h0 &&
     rx_right_level == 4'h0 && rx_left_level == 4'h0 &&
     !tx_right_wr_full && !tx_right_rd_empty && !tx_left_wr_full && !tx_left_rd_empty &&
     !rx_right_wr_full && !rx_right_rd_empty && !rx_left_wr_full && !rx_left_rd_empty)
    |-> status_word == ASR_STATUS_RST)
    else $error("status word differs from reset value");

  AST_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    (pend_q[1] && !(wr_done && hit_status && pwdata[ASR_TXL_BIT])) |=> pend_q[1])
    else $error("tx left pending dropped without a clear");

  AST_IRQ_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    (pend_q & mask_q) == 6'h00 ##1 (pend_q & mask_q) == 6'h00 |=> !irq)
    else $error("interrupt raised with no unmasked pending bit");

  AST_IRQ_RAISE: assert property (@(posedge pclk) disable iff (!presetn)
    (pend_q & mask_q) != 6'h00 |=> irq)
    else $error("interrupt missing for unmasked pending bit");

  AST_TX_FIELD_CODE: assert property (@(posedge pclk) disable iff (!presetn)
    tx_right_wr_full |-> status_word[4:0] == 5'h1f)
    else $error("tx right field not 1f on write while full");

  AST_TX_UNDERRUN_CODE: assert property (@(posedge pclk) disable iff (!presetn)
    (!tx_left_wr_full && tx_left_rd_empty) |-> status_word[12:8] == 5'h1e)
    else $error("tx left field not 1e on read while empty");

  AST_COUNT_MODE: assert property (@(posedge pclk) disable iff (!presetn)
    (!tx_right_wr_full && !tx_right_rd_empty) |->
      status_word[4:0] == (tx_count_mode ? {1'b0, tx_right_level} : 5'h08 - {1'b0, tx_right_level}))
    else $error("tx right field ignores count mode");

  AST_TXR_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_ctl_q[0] && tx_right_level < tx_ctl_q[7:4]) |=> status_word[5])
    else $error("tx right pending not set below threshold");

  AST_W1C: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_done && hit_status && pwdata[ASR_TXR_BIT] && !set_txr) |=> !pend_q[0])
    else $error("tx right pending not cleared by writing one");

  AST_TX_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_ctl_q[2] && (tx_right_rd_empty || tx_left_rd_empty)) |=> status_word[7])
    else $error("tx error pending not set on underrun");

  AST_RX_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_ctl_q[2] && (rx_right_wr_full || rx_left_wr_full)) |=> status_word[15])
    else $error("rx error pending not set on overrun");

  AST_APB_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready)
    else $error("apb access not answered after one wait state");

  AST_TXL_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_left_irq_enable && tx_left_level < tx_level_threshold) |=> status_word[ASR_TXL_BIT])
    else $error("tx left pending not set below threshold");

  AST_RXR_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_right_irq_enable && rx_right_level > rx_level_threshold) |=> status_word[ASR_RXR_BIT])
    else $error("rx right pending not set above threshold");

  AST_RXL_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_left_irq_enable && rx_left_level > rx_level_threshold) |=> status_word[ASR_RXL_BIT])
    else $error("rx left pending not set above threshold");

  AST_TXR_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
    (!tx_right_irq_enable && !pend_q[0]) |=> !pend_q[0])
    else $error("tx right pending set while its enable is off");

  AST_RXE_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
    (!rx_error_irq_enable && !pend_q[5]) |=> !pend_q[5])
    else $error("rx error pending set while its enable is off");

  AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_done && hit_status && pwdata[ASR_TXR_BIT] && set_txr) |=> pend_q[0])
    else $error("tx right pending cleared while its condition lasts");

  AST_WRITE_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (pend_q[2] && wr_done && hit_status && !pwdata[ASR_TXERR_BIT]) |=> pend_q[2])
    else $error("tx error pending dropped by writing zero");

  AST_RXE_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    (pend_q[5] && !(wr_done && hit_status && pwdata[ASR_RXERR_BIT])) |=> pend_q[5])
    else $error("rx error pending dropped without a clear");

  AST_TXE_W1C: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_done && hit_status && pwdata[ASR_TXERR_BIT] && !set_txe) |=> !pend_q[2])
    else $error("tx error pending not cleared by writing one");

  AST_TXR_LIVE: assert property (@(posedge pclk) disable iff (!presetn)
    (!tx_right_wr_full && !tx_right_rd_empty) |-> status_word[4:0] <= {1'b0, ASR_FIFO_DEPTH})
    else $error("tx right field holds an error code after the condition went");

  AST_TXL_LIVE: assert property (@(posedge pclk) disable iff (!presetn)
    (!tx_left_wr_full && !tx_left_rd_empty) |-> status_word[12:8] <= {1'b0, ASR_FIFO_DEPTH})
    else $error("tx left field holds an error code after the condition went");

  AST_TXL_OVERRUN: assert property (@(posedge pclk) disable iff (!presetn)
    tx_left_wr_full |-> status_word[12:8] == ASR_FLD_OVERRUN)
    else $error("tx left field not 1f on write while full");

  AST_TXR_UNDERRUN: assert property (@(posedge pclk) disable iff (!presetn)
    (!tx_right_wr_full && tx_right_rd_empty) |-> status_word[4:0] == ASR_FLD_UNDERRUN)
    else $error("tx right field not 1e on read while empty");

  AST_TXL_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
    (!tx_left_wr_full && !tx_left_rd_empty && tx_count_mode) |-> status_word[12:8] == {1'b0, tx_left_level})
    else $error("tx left field does not show filled words");

  AST_THR_RAW: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_right_irq_enable && tx_right_level >= tx_level_threshold && !pend_q[0]) |=> !pend_q[0])
    else $error("tx right request depends on the count mode");

  AST_WS_FIELD: assert property (@(posedge pclk) disable iff (!presetn)
    !status_word[31] && {status_word[30:29], status_word[23:21]} == ws_bus.length)
    else $error("word-select length misplaced in the status word");

  AST_IRQ_ORIGIN: assert property (@(posedge pclk) disable iff (!presetn)
    irq |-> $past(pend_q & mask_q) != 6'h00)
    else $error("interrupt high with no unmasked pending bit before it");

  AST_PREADY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held longer than one cycle");

  AST_SLVERR_QUAL: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("pslverr without pready");

  AST_RDATA_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && penable && !pwrite && !pready) |=> $stable(prdata))
    else $error("read data changed with no read access");
endmodule

// file: tb.sv
// self-checking bench for the audio serial status register over apb
`timescale 1ns/100ps
module tb;
  import asr_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er, ws_pin, bclk_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, txctl, rxctl, p;
  logic [3:0] txr, txl, rxr, rxl;
  logic [7:0] fl; // full/empty flags, tx right, tx left, rx right, rx left
  logic [4:0] ws_exp;
  int errors, check_count, cyc;
  int pb[6] = '{ASR_TXR_BIT, ASR_TXL_BIT, ASR_TXERR_BIT, ASR_RXR_BIT, ASR_RXL_BIT, ASR_RXERR_BIT};
  int wsn[2] = '{3, 20};

  asr_status i_asr_status (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_right_level(txr), .tx_left_level(txl), .rx_right_level(rxr), .rx_left_level(rxl),
    .tx_right_wr_full(fl[0]), .tx_right_rd_empty(fl[1]), .tx_left_wr_full(fl[2]), .tx_left_rd_empty(fl[3]),
    .rx_right_wr_full(fl[4]), .rx_right_rd_empty(fl[5]), .rx_left_wr_full(fl[6]), .rx_left_rd_empty(fl[7]),
    .word_select_pin(ws_pin), .serial_bit_clock_pin(bclk_pin), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard, sized well above the roughly 1200 cycles the run needs
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checking and bus tasks
  task automatic summarize();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // request held until pready is seen high at a rising edge; no latency assumed
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready seen high ends this wait; otherwise only the bench's cycle ceiling does
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // field reading: error codes first, write-full ahead of read-empty
  function automatic logic [4:0] fld(input logic [3:0] lv, input logic wf, input logic re, input logic m);
    if (wf) return ASR_FLD_OVERRUN;
    if (re) return ASR_FLD_UNDERRUN;
    return m ? {1'b0, lv} : 5'h08 - {1'b0, lv};
  endfunction
  function automatic logic [31:0] exp_st(input logic [31:0] pend);
    return {1'b0, ws_exp[4:3], fld(rxl, fl[6], fl[7], rxctl[3]), ws_exp[2:0], fld(rxr, fl[4], fl[5], rxctl[3]),
      3'b000, fld(txl, fl[2], fl[3], txctl[3]), 3'b000, fld(txr, fl[0], fl[1], txctl[3])} | pend;
  endfunction
  // raise or drop the setting condition of pending bit i (tx levels below 4, rx levels above 4, errors by tx right read-empty and rx left write-full)
  task automatic cond(input int i, input logic on);
    @(posedge pclk);
    case (i)
      0: txr <= on ? 4'h3 : 4'h8;
      1: txl <= on ? 4'h3 : 4'h8;
      2: fl[1] <= on;
      3: rxr <= on ? 4'h5 : 4'h0;
      4: rxl <= on ? 4'h5 : 4'h0;
      default: fl[6] <= on;
    endcase
    wt(3);
  endtask
  task automatic wctl();
    apb(1'b1, ASR_TXCTL_OFS, txctl);
    apb(1'b1, ASR_RXCTL_OFS, rxctl);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    txr = 4'h0; txl = 4'h0; rxr = 4'h0; rxl = 4'h0; fl = 8'h00; ws_pin = 1'b0; bclk_pin = 1'b0;
    ws_exp = 5'h00; txctl = ASR_TXCTL_RST; rxctl = ASR_RXCTL_RST;
    void'($urandom(32'hddebdb6a));
    wt(2);
    presetn <= 1'b1;
    rdc(ASR_STATUS_OFS, ASR_STATUS_RST);
    rdc(ASR_TXCTL_OFS, ASR_TXCTL_RST);
    rdc(ASR_RXCTL_OFS, ASR_RXCTL_RST);
    rdc(ASR_MASK_OFS, ASR_MASK_RST);
    apb(1'b1, ASR_STATUS_OFS, 32'hffffffff);
    rdc(ASR_STATUS_OFS, ASR_STATUS_RST);
    apb(1'b1, ASR_TXCTL_OFS, 32'hffffffff);
    rdc(ASR_TXCTL_OFS, 32'h000000ff);
    apb(1'b1, ASR_MASK_OFS, 32'hffffffff);
    rdc(ASR_MASK_OFS, 32'h0000e0e0);
    apb(1'b1, ASR_MASK_OFS, 32'h0);
    apb(1'b1, ASR_TXCTL_OFS, txctl);
    // the all-ones control word armed both tx level requests; drop them now that the enables are off
    apb(1'b1, ASR_STATUS_OFS, 32'hffffffff);
    rdc(ASR_STATUS_OFS, ASR_STATUS_RST);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h010, 32'h1234);
    chk({31'h0, er}, 32'h1);
    // word-select phases of n bit-clock periods, bit clock at a quarter of pclk
    foreach (wsn[k]) begin
      repeat (3) begin
        @(posedge pclk);
        ws_pin <= ~ws_pin;
        repeat (wsn[k]) begin
          @(posedge pclk);
          bclk_pin <= 1'b1;
          wt(2);
          bclk_pin <= 1'b0;
          @(posedge pclk);
        end
      end
      @(posedge pclk);
      ws_pin <= ~ws_pin;
      wt(6);
      ws_exp = wsn[k][4:0];
      rdc(ASR_STATUS_OFS, exp_st(32'h0));
    end
    // random levels, flags, thresholds and count modes with all requests disabled
    repeat (24) begin
      txctl = {24'h0, 4'($urandom % 16), 1'($urandom % 2), 3'b000};
      rxctl = {24'h0, 4'($urandom % 16), 1'($urandom % 2), 3'b000};
      wctl();
      @(posedge pclk);
      txr <= 4'($urandom % 9); txl <= 4'($urandom % 9); rxr <= 4'($urandom % 9); rxl <= 4'($urandom % 9);
      fl <= 8'($urandom & $urandom & $urandom);
      wt(3);
      rdc(ASR_STATUS_OFS, exp_st(32'h0));
    end
    // each pending bit: set, sticky, write-zero, mask, clear
    @(posedge pclk);
    txr <= 4'h8; txl <= 4'h8; rxr <= 4'h0; rxl <= 4'h0; fl <= 8'h00;
    for (int i = 0; i < 6; i++) begin
      p = 32'h1 << pb[i];
      txctl = {24'h0, 4'h4, 1'($urandom % 2), 3'b000};
      rxctl = {24'h0, 4'h4, 1'b1, 3'b000};
      wctl();
      cond(i, 1'b1);
      rdc(ASR_STATUS_OFS, exp_st(32'h0));
      if (i < 3) txctl[i] = 1'b1;
      else rxctl[i - 3] = 1'b1;
      wctl();
      wt(3);
      apb(1'b1, ASR_STATUS_OFS, p);
      rdc(ASR_STATUS_OFS, exp_st(p));
      cond(i, 1'b0);
      rdc(ASR_STATUS_OFS, exp_st(p));
      apb(1'b1, ASR_STATUS_OFS, 32'h0);
      rdc(ASR_STATUS_OFS, exp_st(p));
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, ASR_MASK_OFS, p);
      wt(2);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, ASR_STATUS_OFS, p);
      rdc(ASR_STATUS_OFS, exp_st(32'h0));
      wt(2);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, ASR_MASK_OFS, 32'h0);
    end
    summarize();
  end
endmodule
